// >>> leqe_pkg.sv
package leqe_pkg;
  // equation array shape
  localparam int unsigned NUM_EQ      = 8;
  localparam int unsigned EQ_IDX_W    = 3;
  localparam int unsigned NUM_EXT     = 16;
  localparam int unsigned NUM_SIG     = 32;   // external signals then equation results
  localparam int unsigned SIG_SEL_W   = 5;
  localparam int unsigned NUM_OPND    = 4;
  localparam int unsigned DLY_W       = 16;
  localparam logic [SIG_SEL_W-1:0] EQ_SIG_BASE = 5'h10;

  // gate operators, kept local to this block
  typedef enum logic [1:0] {
    LEQE_OP_AND  = 2'h0,
    LEQE_OP_OR   = 2'h1,
    LEQE_OP_XOR  = 2'h2,
    LEQE_OP_NAND = 2'h3
  } leqe_op_t;

  // per-slot register layout, slot stride 16 bytes
  localparam logic [11:0] SLOT_BASE       = 12'h000;
  localparam logic [11:0] SLOT_STRIDE     = 12'h010;
  localparam logic [3:0]  OFS_SEL         = 4'h0;
  localparam logic [3:0]  OFS_CTRL        = 4'h4;
  localparam logic [3:0]  OFS_DLY         = 4'h8;
  localparam logic [11:0] STATUS_ADDR     = 12'h100;
  localparam logic [11:0] EXT_ADDR        = 12'h104;
  localparam logic [11:0] CYCLE_ADDR      = 12'h108;

  // ctrl word fields
  localparam int unsigned CTRL_INV_LSB    = 0;
  localparam int unsigned CTRL_OP_LSB     = 4;
  localparam int unsigned CTRL_CLRINV_BIT = 6;
  localparam int unsigned CTRL_CLRSEL_LSB = 8;
  localparam int unsigned CTRL_EN_BIT     = 16;

  // reset values
  localparam logic [31:0] SEL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DLY_RST  = 32'h0000_0000;

  // engine states, gray along idle -> eval -> wrap
  typedef enum logic [1:0] {
    LEQE_ST_IDLE = 2'b00,
    LEQE_ST_EVAL = 2'b01,
    LEQE_ST_WRAP = 2'b11
  } leqe_state_t;
endpackage

// >>> leqe_slot_if.sv
`timescale 1ns/1ps
interface leqe_slot_if;
  import leqe_pkg::*;
  logic             gate_in;
  logic             clear_in;
  logic [DLY_W-1:0] on_dly;
  logic [DLY_W-1:0] off_dly;
  logic             step;
  logic             delayed;
  logic             latched;
  modport engine (output gate_in, output clear_in, output on_dly, output off_dly,
                  output step, input delayed, input latched);
  modport slot   (input gate_in, input clear_in, input on_dly, input off_dly,
                  input step, output delayed, output latched);
endinterface

// >>> leqe_timer_latch.sv
`timescale 1ns/1ps
module leqe_timer_latch
  import leqe_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  leqe_slot_if.slot   sif
);
  logic [DLY_W-1:0] cnt_q;
  logic             delayed_q;
  logic             latched_q;
  logic             delayed_d;

  // one step is one process cycle, so delays are counted in passes
  always_comb begin
    delayed_d = delayed_q;
    if (sif.gate_in != delayed_q) begin
      if (sif.gate_in && cnt_q >= sif.on_dly)   delayed_d = 1'b1;
      if (!sif.gate_in && cnt_q >= sif.off_dly) delayed_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      delayed_q <= 1'b0;
    end else if (sif.step) begin
      delayed_q <= delayed_d;
      // short pulse restarts the count
      if (sif.gate_in == delayed_q || delayed_d != delayed_q) cnt_q <= DLY_W'(1);
      else if (cnt_q != '1) cnt_q <= cnt_q + DLY_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) latched_q <= 1'b0;
    else if (sif.step) begin
      if (sif.clear_in) latched_q <= 1'b0;
      else if (delayed_d) latched_q <= 1'b1;
    end
  end

  assign sif.delayed = delayed_d;
  assign sif.latched = sif.clear_in ? 1'b0 : (delayed_d | latched_q);
endmodule // leqe_timer_latch

// >>> leqe_engine.sv
`timescale 1ns/1ps
// Functional notes
// - each slot gates four operands picked from the shared signal list
// - each of the four operands may be inverted before the gate
// - gate result passes an on-delay and off-delay timer
// - each slot drives an unlatched result and a latched result together
// - the inverse of the latched result is also driven
// - latch clear is a selectable signal with optional inversion
// - clear wins when set and clear are both true
// - slot results are selectable as operands of other slots
// - one pass evaluates slots in ascending index order from slot 0
// - a new pass starts one wrap cycle after the last slot
// - a lower slot feeding a higher one gives this pass's value
// - a higher slot feeding a lower one gives last pass's value
module leqe_engine
  import leqe_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [31:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_EXT-1:0]   ext_signal,
  output logic      [NUM_EQ-1:0]    equation_result,
  output logic      [NUM_EQ-1:0]    equation_latched,
  output logic      [NUM_EQ-1:0]    equation_latched_n,
  output logic                      pass_done
);
  logic [31:0]          sel_q  [NUM_EQ];
  logic [31:0]          ctrl_q [NUM_EQ];
  logic [31:0]          dly_q  [NUM_EQ];
  logic [NUM_EXT-1:0]   ext_s1_q, ext_s2_q, ext_s3_q, ext_q;
  logic [NUM_EQ-1:0]    res_q, lat_q;
  logic [EQ_IDX_W-1:0]  idx_q;
  logic [31:0]          pass_cnt_q;
  leqe_state_t          st_q;
  logic [NUM_SIG-1:0]   sig_list;
  logic [NUM_EQ-1:0]    delayed_w, latched_w;
  logic                 gate_w, clear_w;
  logic [NUM_OPND-1:0]  opnd_w;
  logic [31:0]          rd_d;
  logic                 addr_ok;
  logic [3:0]           slot_reg;
  logic [EQ_IDX_W-1:0]  slot_idx;
  logic                 in_slots;
  logic                 acc_w;
  leqe_op_t             op_w;

  // three-stage sync, accept a change once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_q    <= '0;
    end else begin
      ext_s1_q <= ext_signal;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      for (int i = 0; i < NUM_EXT; i++) begin
        if (ext_s2_q[i] == ext_s3_q[i]) ext_q[i] <= ext_s3_q[i];
      end
    end
  end

  // res_q holds newest value: already updated for lower slots this pass
  // unused top entries of the list read as zero
  assign sig_list = {8'h00, res_q, ext_q};

  // per-slot timer and latch
  genvar g;
  generate
    for (g = 0; g < NUM_EQ; g++) begin : g_slot
      leqe_slot_if sif ();
      assign sif.gate_in  = gate_w;
      assign sif.clear_in = clear_w;
      assign sif.on_dly   = dly_q[g][DLY_W-1:0];
      assign sif.off_dly  = dly_q[g][2*DLY_W-1:DLY_W];
      assign sif.step     = (st_q == LEQE_ST_EVAL) && (idx_q == EQ_IDX_W'(g));
      assign delayed_w[g] = sif.delayed;
      assign latched_w[g] = sif.latched;
      leqe_timer_latch u_tl (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
      );
    end
  endgenerate

  // operands of the slot under evaluation
  always_comb begin
    logic [SIG_SEL_W-1:0] s;
    s      = '0;
    opnd_w = '0;
    for (int k = 0; k < NUM_OPND; k++) begin
      s = sel_q[idx_q][k*8 +: SIG_SEL_W];
      opnd_w[k] = sig_list[s] ^ ctrl_q[idx_q][CTRL_INV_LSB+k];
    end
  end

  assign op_w = leqe_op_t'(ctrl_q[idx_q][CTRL_OP_LSB +: 2]);

  always_comb begin
    unique case (op_w)
      LEQE_OP_AND:  gate_w = &opnd_w;
      LEQE_OP_OR:   gate_w = |opnd_w;
      LEQE_OP_XOR:  gate_w = ^opnd_w;
      LEQE_OP_NAND: gate_w = ~&opnd_w;
    endcase
  end

  assign clear_w = sig_list[ctrl_q[idx_q][CTRL_CLRSEL_LSB +: SIG_SEL_W]]
                   ^ ctrl_q[idx_q][CTRL_CLRINV_BIT];

  // sequencer: one slot per clock, slot 0 up to the last, then again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= LEQE_ST_IDLE;
      idx_q <= '0;
    end else begin
      unique case (st_q)
        LEQE_ST_IDLE: st_q <= LEQE_ST_EVAL;
        LEQE_ST_EVAL: begin
          if (idx_q == EQ_IDX_W'(NUM_EQ-1)) st_q <= LEQE_ST_WRAP;
          else idx_q <= idx_q + EQ_IDX_W'(1);
        end
        LEQE_ST_WRAP: begin
          idx_q <= '0;
          st_q  <= LEQE_ST_EVAL;
        end
        default: st_q <= LEQE_ST_IDLE;
      endcase
    end
  end

  // results update in place, so later slots see them this pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
      lat_q <= '0;
    end else if (st_q == LEQE_ST_EVAL) begin
      res_q[idx_q] <= delayed_w[idx_q] & ctrl_q[idx_q][CTRL_EN_BIT];
      lat_q[idx_q] <= latched_w[idx_q] & ctrl_q[idx_q][CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_cnt_q <= '0;
      pass_done  <= 1'b0;
    end else begin
      pass_done <= (st_q == LEQE_ST_WRAP);
      if (st_q == LEQE_ST_WRAP) pass_cnt_q <= pass_cnt_q + 32'h0000_0001;
    end
  end

  assign equation_result    = res_q;
  assign equation_latched   = lat_q;
  assign equation_latched_n = ~lat_q;

  // APB slave, zero wait states
  assign in_slots = (paddr[11:0] < STATUS_ADDR) && (paddr[31:12] == '0);
  assign slot_idx = paddr[6:4];
  assign slot_reg = paddr[3:0];
  assign acc_w    = psel && penable;
  assign pready   = 1'b1;

  always_comb begin
    rd_d    = 32'h0000_0000;
    addr_ok = 1'b1;
    if (in_slots && paddr[11:7] == 5'h00) begin
      unique case (slot_reg)
        OFS_SEL:  rd_d = sel_q[slot_idx];
        OFS_CTRL: rd_d = ctrl_q[slot_idx];
        OFS_DLY:  rd_d = dly_q[slot_idx];
        default:  addr_ok = 1'b0;
      endcase
    end else if (paddr == {20'h00000, STATUS_ADDR}) begin
      rd_d = {16'h0000, lat_q, res_q};
    end else if (paddr == {20'h00000, EXT_ADDR}) begin
      rd_d = {16'h0000, ext_q};
    end else if (paddr == {20'h00000, CYCLE_ADDR}) begin
      rd_d = pass_cnt_q;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= !addr_ok || (pwrite && !in_slots && addr_ok);
    end
  end

  generate
    for (g = 0; g < NUM_EQ; g++) begin : g_regs
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_q[g]  <= SEL_RST;
          ctrl_q[g] <= CTRL_RST;
          dly_q[g]  <= DLY_RST;
        end else if (acc_w && pwrite && in_slots && addr_ok
                     && paddr[11:7] == 5'h00 && slot_idx == EQ_IDX_W'(g)) begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              if (slot_reg == OFS_SEL)  sel_q[g][b*8 +: 8]  <= pwdata[b*8 +: 8];
              if (slot_reg == OFS_CTRL) ctrl_q[g][b*8 +: 8] <= pwdata[b*8 +: 8];
              if (slot_reg == OFS_DLY)  dly_q[g][b*8 +: 8]  <= pwdata[b*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // checks
  order_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && idx_q != EQ_IDX_W'(NUM_EQ-1))
      |=> (st_q == LEQE_ST_EVAL && idx_q == $past(idx_q) + EQ_IDX_W'(1)))
    else $error("slot order broken");
  pass_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && idx_q == EQ_IDX_W'(NUM_EQ-1))
      |=> st_q == LEQE_ST_WRAP ##1 (st_q == LEQE_ST_EVAL && idx_q == '0))
    else $error("pass did not restart");
  latch_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    equation_latched_n == ~equation_latched)
    else $error("inverted latch mismatch");
  clear_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && clear_w) |=> !lat_q[$past(idx_q)])
    else $error("clear did not dominate");
  latch_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && !clear_w && delayed_w[idx_q] && ctrl_q[idx_q][CTRL_EN_BIT])
      |=> lat_q[$past(idx_q)])
    else $error("latch did not set");
  result_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && ctrl_q[idx_q][CTRL_EN_BIT])
      |=> res_q[$past(idx_q)] == $past(delayed_w[idx_q]))
    else $error("result not stored");
  zero_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && dly_q[idx_q][DLY_W-1:0] == '0 && gate_w)
      |-> delayed_w[idx_q])
    else $error("zero on-delay not immediate");
  zero_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == LEQE_ST_EVAL && dly_q[idx_q][2*DLY_W-1:DLY_W] == '0 && !gate_w)
      |-> !delayed_w[idx_q])
    else $error("zero off-delay not immediate");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("apb not ready");
  pass_cov: cover property (@(posedge pclk) disable iff (!presetn) pass_done);
  latch_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(lat_q[0]));
  clear_cov: cover property (@(posedge pclk) disable iff (!presetn)
    st_q == LEQE_ST_EVAL && clear_w && delayed_w[idx_q]);
endmodule // leqe_engine

// >>> leqe_sig_src.sv
`timescale 1ns/1ps
module leqe_sig_src
  import leqe_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [NUM_EXT-1:0] want,
  input  wire logic [3:0]         lag,
  output logic      [NUM_EXT-1:0] ext_signal
);
  logic [3:0] cnt_q;

  // a slow source lets a new level through lag+1 cycles after it is asked for
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 4'h0;
      ext_signal <= '0;
    end else if (want == ext_signal) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= lag) begin
      ext_signal <= want;
      cnt_q      <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // leqe_sig_src

// >>> leqe_engine_tb.sv
`timescale 1ns/1ps
module leqe_engine_tb;
  import leqe_pkg::*;
  localparam logic [31:0] EN = 32'h0001_0000;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, pass_done, err;
  logic [31:0]       paddr, pwdata, prdata, rd;
  logic [3:0]        pstrb, lag;
  logic [NUM_EXT-1:0] want, ext_signal;
  logic [NUM_EQ-1:0] res, lat, lat_n;
  int                num_errors, check_count;

  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    want = '0;
    lag = 4'h0;
  end
  always #25 pclk = ~pclk;

  leqe_engine DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_signal(ext_signal), .equation_result(res),
    .equation_latched(lat), .equation_latched_n(lat_n), .pass_done(pass_done));
  leqe_sig_src src (.pclk(pclk), .presetn(presetn), .want(want), .lag(lag),
    .ext_signal(ext_signal));

  task chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; print_verdict; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // b 0..7 watches a slot result, 8 watches the pass strobe
  task till(input int b, input logic v, output int n);
    n = 0;
    do begin @(posedge pclk); n++; end while ((b < 8 ? res[b] : pass_done) !== v && n < 80);
    if (n >= 80) begin num_errors++; print_verdict; end
  endtask

  function automatic logic [31:0] sel4(input logic [4:0] v);
    return {4{3'h0, v}};
  endfunction

  task cfg(input int s, input logic [31:0] sel, ctl, dly);
    apb(1'b1, 32'(16 * s) + OFS_SEL, sel);
    apb(1'b1, 32'(16 * s) + OFS_CTRL, ctl);
    apb(1'b1, 32'(16 * s) + OFS_DLY, dly);
  endtask

  task t_regs;
    chk("latched_n rst", lat_n, 32'h0000_00FF);
    apb(1'b0, 32'h0000_0014, 32'h0);
    chk("ctrl rst", rd, CTRL_RST);
    apb(1'b0, 32'h0000_0200, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 32'(STATUS_ADDR), 32'hFFFF_FFFF);
    chk("ro write err", err, 1'b1);
    apb(1'b1, 32'h0000_0028, 32'h0003_0002);
    apb(1'b0, 32'h0000_0028, 32'h0);
    chk("dly rw", rd, 32'h0003_0002);
  endtask

  task t_gate;
    logic [3:0] pat [4];
    logic [3:0] a;
    logic       e;
    pat = '{4'h5, 4'hA, 4'h4, 4'h0};
    lag = 4'h3;
    for (int op = 0; op < 4; op++) begin
      for (int i = 0; i < 4; i++) begin
        cfg(3, 32'h0302_0100, EN | (32'(op) << CTRL_OP_LSB) | 32'h0000_0005, 32'h0);
        want <= {12'h000, pat[i]};
        cyc(40); // sync plus three passes
        a = pat[i] ^ 4'h5;
        e = op == 0 ? &a : op == 1 ? |a : op == 2 ? ^a : ~&a;
        chk("gate", res[3], e);
      end
    end
    lag = 4'h0;
  endtask

  task t_cascade;
    int n;
    cfg(2, sel4(5'h00), EN | 32'h0000_0010, 32'h0);
    cfg(0, sel4(EQ_SIG_BASE + 5'h02), EN | 32'h0000_0010, 32'h0);
    cfg(1, sel4(EQ_SIG_BASE), EN | 32'h0000_0010, 32'h0);
    want <= '0;
    cyc(30);
    want <= 16'h0001;
    till(2, 1'b1, n);
    till(0, 1'b1, n);
    chk("descending age", n, 7);
    till(1, 1'b1, n);
    chk("ascending age", n, 1);
    till(8, 1'b1, n);
    till(8, 1'b1, n);
    chk("pass length", n, 9);
  endtask

  task t_timer;
    int n;
    want <= '0;
    cfg(4, sel4(5'h01), EN | 32'h0000_0210, 32'h0002_0003);
    cyc(30);
    want <= 16'h0002;
    cyc(18); // exactly two evaluations, one short of the on-delay
    want <= '0;
    cyc(40);
    chk("short pulse", lat[4], 1'b0);
    want <= 16'h0002;
    till(4, 1'b1, n);
    chk("on delay", n >= 20 && n <= 36, 1'b1);
    chk("latch set", lat[4], 1'b1);
    want <= '0;
    till(4, 1'b0, n);
    chk("off delay", n >= 11 && n <= 27, 1'b1);
    chk("latch hold", lat[4], 1'b1);
    want <= 16'h0006;
    cyc(45);
    chk("set during clear", res[4], 1'b1);
    chk("clear wins", lat[4], 1'b0);
    chk("inverse out", lat_n[4], 1'b1);
    want <= 16'h0002;
    cyc(30);
    chk("relatch", lat[4], 1'b1);
    apb(1'b1, 32'h0000_0044, EN | 32'h0000_0250);
    cyc(30);
    chk("clear invert", lat[4], 1'b0);
  endtask

  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(2);
    t_regs;
    t_gate;
    t_cascade;
    t_timer;
    print_verdict;
  end
endmodule // leqe_engine_tb
